// ==== include/adc_seq_pkg.sv ====
// package: constants, field layouts and carriers of the conversion sequencer
package adc_seq_pkg;

   localparam int NUM_CONV = 2;
   localparam int NUM_CH = 8;
   localparam int RES_W = 10;
   localparam int CH_W = 3;
   localparam int BIT_CYCLES = 4;

   // register byte offsets, and result page codes matched against address bits 7:5
   localparam logic [7:0] OFS_SCAN0 = 8'h00;
   localparam logic [7:0] OFS_SCAN1 = 8'h04;
   localparam logic [7:0] OFS_TRIG_SEL = 8'h08;
   localparam logic [7:0] OFS_EDGE = 8'h0C;
   localparam logic [2:0] RES0_PAGE = 3'h1;
   localparam logic [2:0] RES1_PAGE = 3'h2;

   // reset values
   localparam logic [15:0] SCAN_RST = 16'h0000;
   localparam logic [3:0] TRIG_SEL_RST = 4'h0;
   localparam logic [3:0] EDGE_RST = 4'h0;

   // trigger field codes
   localparam logic [2:0] TRIG_SW = 3'h0;
   localparam logic [2:0] TRIG_TIMER = 3'h1;
   localparam logic [2:0] TRIG_EXT = 3'h7;

   // external edge codes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic enable;
      logic status;
      logic fixed0;
      logic single;
      logic poll;
      logic [2:0] trig;
      logic [3:0] start_ch;
      logic [3:0] end_ch;
   } scan_mode_t;

   typedef enum logic [1:0] {ST_IDLE, ST_STANDBY, ST_CONV} seq_state_t;

endpackage : adc_seq_pkg

// ==== logic/sar_engine.sv ====
// successive approximation engine driving the dac code of one converter
`timescale 1ns/1ns
module sar_engine #(
   parameter int RES_W = adc_seq_pkg::RES_W,
   parameter int BIT_CYCLES = adc_seq_pkg::BIT_CYCLES
) (
   // clock, reset and clock enable
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // control
   input wire logic start,
   input wire logic abort,
   // comparator, already synchronised
   input wire logic cmp_above,
   // results
   output logic [RES_W-1:0] dac_code,
   output logic done,
   output logic [RES_W-1:0] result
);

   logic [RES_W-1:0] trial_r;
   logic [RES_W-1:0] kept;
   logic [$clog2(BIT_CYCLES)-1:0] wait_r;
   logic busy_r;

   // comparator low: the trial bit overshoots and is dropped
   assign kept = cmp_above ? dac_code : (dac_code & ~trial_r);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         busy_r <= 1'b0;
         trial_r <= '0;
         wait_r <= '0;
         dac_code <= '0;
         done <= 1'b0;
         result <= '0;
      end else if (clk_en) begin
         done <= 1'b0;
         if (abort) begin
            busy_r <= 1'b0;
            trial_r <= '0;
         end else if (start) begin
            busy_r <= 1'b1;
            trial_r <= {1'b1, {(RES_W-1){1'b0}}};
            dac_code <= {1'b1, {(RES_W-1){1'b0}}};
            wait_r <= '0;
         end else if (busy_r) begin
            // settle time covers dac, comparator and the two-stage synchroniser
            if (wait_r == ($clog2(BIT_CYCLES))'(BIT_CYCLES-1)) begin
               wait_r <= '0;
               if (trial_r[0]) begin
                  busy_r <= 1'b0;
                  done <= 1'b1;
                  result <= kept;
                  dac_code <= kept;
               end else begin
                  dac_code <= kept | (trial_r >> 1);
               end
               trial_r <= trial_r >> 1;
            end else begin
               wait_r <= wait_r + 1'b1;
            end
         end
      end
   end

endmodule : sar_engine

// ==== logic/adc_conversion_sequencer.sv ====
// two-converter conversion sequencer with an axi4-lite register slave
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module adc_conversion_sequencer (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // internal timer events, one-cycle pulses on sys_clk
   input wire logic timer0_underflow_event,
   input wire logic timer1_underflow_event,
   input wire logic compare_match_event_a,
   input wire logic compare_match_event_b,
   // external trigger pins
   input wire logic ext_trigger_pin_0,
   input wire logic ext_trigger_pin_1,
   // comparator outputs of the analog front ends
   input wire logic cmp_above_0,
   input wire logic cmp_above_1,
   // analog input select and dac codes
   output logic [2:0] analog_in_conv0,
   output logic [2:0] analog_in_conv1,
   output logic [9:0] dac_code_0,
   output logic [9:0] dac_code_1,
   // conversion done pulses
   output logic conv_done_irq_0,
   output logic conv_done_irq_1
);

   localparam int NC = adc_seq_pkg::NUM_CONV;
   localparam int RW = adc_seq_pkg::RES_W;
   localparam int CW = adc_seq_pkg::CH_W;

   //--------------------------------------------------------------
   // shared state
   //--------------------------------------------------------------
   logic [RW-1:0] res_r [NC][adc_seq_pkg::NUM_CH];
   adc_seq_pkg::scan_mode_t scan_rd [NC];
   logic [3:0] trig_sel_r;
   logic [3:0] edge_sel_r;
   logic [3:0] timer_vec;
   logic [NC-1:0] ext_pin;
   logic [NC-1:0] cmp_pin;
   logic [NC-1:0] done_irq_r;
   logic [CW-1:0] ch_out [NC];
   logic [RW-1:0] dac_out [NC];

   assign timer_vec = {compare_match_event_b, compare_match_event_a,
                       timer1_underflow_event, timer0_underflow_event};
   assign ext_pin = {ext_trigger_pin_1, ext_trigger_pin_0};
   assign cmp_pin = {cmp_above_1, cmp_above_0};
   assign conv_done_irq_0 = done_irq_r[0];
   assign conv_done_irq_1 = done_irq_r[1];
   assign analog_in_conv0 = ch_out[0];
   assign analog_in_conv1 = ch_out[1];
   assign dac_code_0 = dac_out[0];
   assign dac_code_1 = dac_out[1];

   //--------------------------------------------------------------
   // axi4-lite write channel
   //--------------------------------------------------------------
   logic aw_have_r;
   logic w_have_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_go;
   logic wr_mapped;

   // one write in flight: both channels close until the response is taken
   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   assign wr_mapped = (aw_addr_r == adc_seq_pkg::OFS_SCAN0) ||
                      (aw_addr_r == adc_seq_pkg::OFS_SCAN1) ||
                      (aw_addr_r == adc_seq_pkg::OFS_TRIG_SEL) ||
                      (aw_addr_r == adc_seq_pkg::OFS_EDGE) ||
                      (aw_addr_r[7:5] == adc_seq_pkg::RES0_PAGE) ||
                      (aw_addr_r[7:5] == adc_seq_pkg::RES1_PAGE);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= adc_seq_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (!aw_have_r && !s_axi_bvalid) begin
            s_axi_awready <= !(s_axi_awvalid && s_axi_awready);
         end
         if (!w_have_r && !s_axi_bvalid) begin
            s_axi_wready <= !(s_axi_wvalid && s_axi_wready);
         end
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // trigger select and edge select registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         trig_sel_r <= adc_seq_pkg::TRIG_SEL_RST;
         edge_sel_r <= adc_seq_pkg::EDGE_RST;
      end else if (clk_en && wr_go && w_strb_r[0]) begin
         if (aw_addr_r == adc_seq_pkg::OFS_TRIG_SEL) begin
            trig_sel_r <= w_data_r[3:0];
         end
         if (aw_addr_r == adc_seq_pkg::OFS_EDGE) begin
            edge_sel_r <= w_data_r[3:0];
         end
      end
   end

   //--------------------------------------------------------------
   // axi4-lite read channel
   //--------------------------------------------------------------
   logic [31:0] rd_data;
   logic rd_ok;

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok = 1'b1;
      if (s_axi_araddr == adc_seq_pkg::OFS_SCAN0) begin
         rd_data = {16'h0000, scan_rd[0]};
      end else if (s_axi_araddr == adc_seq_pkg::OFS_SCAN1) begin
         rd_data = {16'h0000, scan_rd[1]};
      end else if (s_axi_araddr == adc_seq_pkg::OFS_TRIG_SEL) begin
         rd_data = {28'h0000000, trig_sel_r};
      end else if (s_axi_araddr == adc_seq_pkg::OFS_EDGE) begin
         rd_data = {28'h0000000, edge_sel_r};
      end else if (s_axi_araddr[7:5] == adc_seq_pkg::RES0_PAGE) begin
         rd_data = {22'h000000, res_r[0][s_axi_araddr[4:2]]};
      end else if (s_axi_araddr[7:5] == adc_seq_pkg::RES1_PAGE) begin
         rd_data = {22'h000000, res_r[1][s_axi_araddr[4:2]]};
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= adc_seq_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   //--------------------------------------------------------------
   // one sequencer per converter
   //--------------------------------------------------------------
   for (genvar k = 0; k < NC; k++) begin : g_conv
      adc_seq_pkg::scan_mode_t mode_r;
      adc_seq_pkg::scan_mode_t wr_mode;
      adc_seq_pkg::seq_state_t state_r;
      logic [CW-1:0] ch_r;
      logic [CW-1:0] first_ch;
      logic [CW-1:0] wr_first_ch;
      logic sar_start_r;
      logic sar_done;
      logic [RW-1:0] sar_result;
      logic [1:0] ext_sync_r;
      logic ext_prev_r;
      logic [1:0] cmp_sync_r;
      logic [1:0] edge_code;
      logic ext_edge;
      logic trig_hit;
      logic wr_hit;
      logic wr_trig_mode;
      logic last_conv;

      assign wr_hit = wr_go && (aw_addr_r == ((k == 1) ? adc_seq_pkg::OFS_SCAN1 :
                                                   adc_seq_pkg::OFS_SCAN0));

      // byte-lane merge; status and the fixed zero bit are not writable
      always_comb begin
         wr_mode = mode_r;
         if (w_strb_r[0]) begin
            wr_mode[7:0] = w_data_r[7:0];
         end
         if (w_strb_r[1]) begin
            wr_mode[15:8] = w_data_r[15:8];
         end
         wr_mode.status = 1'b0;
         wr_mode.fixed0 = 1'b0;
      end

      // single mode uses the end field as its channel
      assign first_ch = mode_r.single ? mode_r.end_ch[CW-1:0] : mode_r.start_ch[CW-1:0];
      assign wr_first_ch = wr_mode.single ? wr_mode.end_ch[CW-1:0] :
                           wr_mode.start_ch[CW-1:0];
      assign wr_trig_mode = (wr_mode.trig == adc_seq_pkg::TRIG_TIMER) ||
                            (wr_mode.trig == adc_seq_pkg::TRIG_EXT);
      assign last_conv = mode_r.single || (ch_r == mode_r.end_ch[CW-1:0]);

      // pin and comparator synchronisers; edge detect reads only the second stage
      always_ff @(posedge sys_clk or negedge rstn) begin
         if (!rstn) begin
            ext_sync_r <= 2'b00;
            ext_prev_r <= 1'b0;
            cmp_sync_r <= 2'b00;
         end else if (clk_en) begin
            ext_sync_r <= {ext_sync_r[0], ext_pin[k]};
            ext_prev_r <= ext_sync_r[1];
            cmp_sync_r <= {cmp_sync_r[0], cmp_pin[k]};
         end
      end

      assign edge_code = edge_sel_r[2*k +: 2];
      always_comb begin
         unique case (edge_code)
            adc_seq_pkg::EDGE_NONE: ext_edge = 1'b0;
            adc_seq_pkg::EDGE_RISE: ext_edge = ext_sync_r[1] && !ext_prev_r;
            adc_seq_pkg::EDGE_FALL: ext_edge = !ext_sync_r[1] && ext_prev_r;
            adc_seq_pkg::EDGE_BOTH: ext_edge = ext_sync_r[1] != ext_prev_r;
         endcase
      end

      always_comb begin
         trig_hit = 1'b0;
         if (mode_r.trig == adc_seq_pkg::TRIG_TIMER) begin
            trig_hit = timer_vec[trig_sel_r[2*k +: 2]];
         end else if (mode_r.trig == adc_seq_pkg::TRIG_EXT) begin
            trig_hit = ext_edge;
         end
      end

      // sequencing; a register write outranks a completion in the same cycle
      always_ff @(posedge sys_clk or negedge rstn) begin
         if (!rstn) begin
            mode_r <= adc_seq_pkg::SCAN_RST;
            state_r <= adc_seq_pkg::ST_IDLE;
            ch_r <= '0;
            sar_start_r <= 1'b0;
            done_irq_r[k] <= 1'b0;
         end else if (clk_en) begin
            sar_start_r <= 1'b0;
            done_irq_r[k] <= 1'b0;
            if (wr_hit) begin
               mode_r <= wr_mode;
               ch_r <= wr_first_ch;
               if (!wr_mode.enable) begin
                  state_r <= adc_seq_pkg::ST_IDLE;
               end else if (state_r == adc_seq_pkg::ST_CONV || !wr_trig_mode) begin
                  state_r <= adc_seq_pkg::ST_CONV;
                  sar_start_r <= 1'b1;
               end else begin
                  state_r <= adc_seq_pkg::ST_STANDBY;
               end
            end else if (state_r == adc_seq_pkg::ST_STANDBY && trig_hit) begin
               state_r <= adc_seq_pkg::ST_CONV;
               ch_r <= first_ch;
               sar_start_r <= 1'b1;
            end else if (state_r == adc_seq_pkg::ST_CONV && sar_done) begin
               if (last_conv) begin
                  done_irq_r[k] <= 1'b1;
                  if (mode_r.trig == adc_seq_pkg::TRIG_TIMER ||
                      mode_r.trig == adc_seq_pkg::TRIG_EXT) begin
                     state_r <= adc_seq_pkg::ST_STANDBY;
                  end else if (mode_r.poll) begin
                     ch_r <= first_ch;
                     sar_start_r <= 1'b1;
                  end else begin
                     state_r <= adc_seq_pkg::ST_IDLE;
                     mode_r.enable <= 1'b0;
                  end
               end else begin
                  ch_r <= ch_r + 1'b1;
                  sar_start_r <= 1'b1;
               end
            end
         end
      end

      // aborted conversions never reach the result registers
      always_ff @(posedge sys_clk or negedge rstn) begin
         if (!rstn) begin
            for (int i = 0; i < adc_seq_pkg::NUM_CH; i++) begin
               res_r[k][i] <= '0;
            end
         end else if (clk_en && state_r == adc_seq_pkg::ST_CONV && sar_done && !wr_hit) begin
            res_r[k][ch_r] <= sar_result;
         end
      end

      always_comb begin
         scan_rd[k] = mode_r;
         scan_rd[k].status = (state_r != adc_seq_pkg::ST_IDLE);
      end

      assign ch_out[k] = ch_r;

      sar_engine #(
         .RES_W(RW),
         .BIT_CYCLES(adc_seq_pkg::BIT_CYCLES)
      ) u_sar (
         .sys_clk(sys_clk),
         .rstn(rstn),
         .clk_en(clk_en),
         .start(sar_start_r),
         .abort(wr_hit && state_r == adc_seq_pkg::ST_CONV),
         .cmp_above(cmp_sync_r[1]),
         .dac_code(dac_out[k]),
         .done(sar_done),
         .result(sar_result)
      );
   end

endmodule : adc_conversion_sequencer

// ==== verif/adc_seq_checker_asserts.sv ====
// checker: bus handshake and done pulse properties of the sequencer
`timescale 1ns/1ns
module adc_seq_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // done pulses
   input wire logic conv_done_irq_0,
   input wire logic conv_done_irq_1
);
   logic [7:0] wa_r;
   // address of the write now being answered
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn) wa_r <= 8'h00;
      else if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   property p_aw_hold;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_hold: assert property (p_aw_hold)
      else $error("write ready high while response pending");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data not held");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block)
      else $error("read address accepted while data pending");
   // a conversion takes 41 cycles, so two pulses can never be this close
   property p_irq0_gap;
      conv_done_irq_0 |=> !conv_done_irq_0 [*8];
   endproperty
   a_irq0_gap: assert property (p_irq0_gap)
      else $error("converter 0 done pulse too close");
   property p_irq1_gap;
      conv_done_irq_1 |=> !conv_done_irq_1 [*8];
   endproperty
   a_irq1_gap: assert property (p_irq1_gap)
      else $error("converter 1 done pulse too close");
   property p_abort0;
      $rose(s_axi_bvalid) && wa_r == adc_seq_pkg::OFS_SCAN0 |=> !conv_done_irq_0 [*8];
   endproperty
   a_abort0: assert property (p_abort0)
      else $error("converter 0 done right after mode write");
   property p_abort1;
      $rose(s_axi_bvalid) && wa_r == adc_seq_pkg::OFS_SCAN1 |=> !conv_done_irq_1 [*8];
   endproperty
   a_abort1: assert property (p_abort1)
      else $error("converter 1 done right after mode write");
endmodule : adc_seq_checker

bind adc_conversion_sequencer adc_seq_checker chk_u (.sys_clk(sys_clk), .rstn(rstn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .conv_done_irq_0(conv_done_irq_0),
   .conv_done_irq_1(conv_done_irq_1));

// ==== verif/analog_front_model.sv ====
// analog front end: one fixed level per input and a comparator
`timescale 1ns/1ns
module analog_front_model #(
   parameter logic [6:0] LEVEL = 7'h15
) (
   // channel and trial code
   input wire logic [2:0] sel,
   input wire logic [9:0] dac_code,
   // decision
   output logic cmp_above
);
   // distinct level per channel so a wrong channel shows in the result
   assign cmp_above = {sel, LEVEL} >= dac_code;
endmodule : analog_front_model

// ==== verif/tb_adc_conversion_sequencer.sv ====
// testbench: register accesses, trigger modes and results of the sequencer
`timescale 1ns/1ns
module tb_adc_conversion_sequencer;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid;
   logic [3:0] tev = 4'h0;
   logic ce = 1'b1;
   logic [1:0] pin = 2'h0, cmp, irq;
   logic [2:0] sel0, sel1;
   logic [9:0] dac0, dac1;
   int fails = 0, n_tests = 0, ic0 = 0, ic1 = 0, k, b;
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (irq[0] === 1'b1) ic0 <= ic0 + 1;
      if (irq[1] === 1'b1) ic1 <= ic1 + 1;
   end
   adc_conversion_sequencer dut_u (.sys_clk(sys_clk), .rstn(rstn), .clk_en(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timer0_underflow_event(tev[0]), .timer1_underflow_event(tev[1]),
      .compare_match_event_a(tev[2]), .compare_match_event_b(tev[3]),
      .ext_trigger_pin_0(pin[0]), .ext_trigger_pin_1(pin[1]),
      .cmp_above_0(cmp[0]), .cmp_above_1(cmp[1]), .analog_in_conv0(sel0),
      .analog_in_conv1(sel1), .dac_code_0(dac0), .dac_code_1(dac1),
      .conv_done_irq_0(irq[0]), .conv_done_irq_1(irq[1]));
   analog_front_model #(.LEVEL(7'h15)) am0 (.sel(sel0), .dac_code(dac0), .cmp_above(cmp[0]));
   analog_front_model #(.LEVEL(7'h6A)) am1 (.sel(sel1), .dac_code(dac1), .cmp_above(cmp[1]));
   task finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   // each handshake sampled mid-cycle, released after the edge that took it
   task wr(input logic [7:0] a, input logic [31:0] dv);
      int i;
      logic ta, tw, tb;
      tb = 1'b0;
      i = 0;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb) begin
         @(negedge sys_clk);
         ta = awvalid && awready === 1'b1;
         tw = wvalid && wready === 1'b1;
         tb = bvalid === 1'b1;
         r = bresp;
         @(posedge sys_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         if (++i > 200) begin
            fails++;
            finish_test();
         end
      end
   endtask : wr
   task rd(input logic [7:0] a);
      int i;
      logic ta, tg;
      tg = 1'b0;
      i = 0;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tg) begin
         @(negedge sys_clk);
         ta = arvalid && arready === 1'b1;
         tg = rvalid === 1'b1;
         d = rdata;
         r = rresp;
         @(posedge sys_clk);
         if (ta) arvalid <= 1'b0;
         if (tg) rready <= 1'b0;
         if (++i > 200) begin
            fails++;
            finish_test();
         end
      end
   endtask : rd
   task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(what, d, exp);
   endtask : rchk
   task wirq(input int c, input int n);
      int i;
      for (i = 0; (c ? ic1 : ic0) < n; i++) begin
         if (i > 600) begin
            fails++;
            finish_test();
         end
         @(posedge sys_clk);
      end
   endtask : wirq
   task pulse(input int e);
      @(posedge sys_clk);
      tev[e] <= 1'b1;
      @(posedge sys_clk);
      tev <= 4'h0;
   endtask : pulse
   function automatic logic [31:0] lvl(input int c, input int ch);
      return {22'h0, 3'(ch), (c ? 7'h6A : 7'h15)};
   endfunction : lvl
   initial begin
      cyc(20);
      rstn <= 1'b1;
      rchk("mode0 reset", 8'h00, 32'h0);
      rchk("select reset", 8'h08, 32'h0);
      rd(8'h10);
      chk("unmapped resp", {30'h0, r}, {30'h0, adc_seq_pkg::RESP_SLVERR});
      wr(8'h10, 32'h0);
      chk("unmapped wr resp", {30'h0, r}, {30'h0, adc_seq_pkg::RESP_SLVERR});
      wr(8'h00, 32'h9003);
      chk("mode wr resp", {30'h0, r}, {30'h0, adc_seq_pkg::RESP_OKAY});
      wirq(0, 1);
      rchk("single status", 8'h00, 32'h1003);
      rchk("single result", 8'h2C, lvl(0, 3));
      cyc(100);
      chk("no restart", ic0, 1);
      wr(8'h04, 32'h8024);
      wirq(1, 1);
      rchk("scan status", 8'h04, 32'h0024);
      for (k = 1; k < 6; k++) begin
         rchk("scan result", 8'h40 + 4 * k, (k > 1 && k < 5) ? lvl(1, k) : 0);
      end
      wr(8'h00, 32'h9805);
      wirq(0, 3);
      rchk("poll status", 8'h00, 32'hD805);
      rchk("poll result", 8'h34, lvl(0, 5));
      wr(8'h00, 32'h0);
      b = ic0;
      cyc(100);
      chk("poll stopped", ic0, b);
      wr(8'h00, 32'h9000);
      // second write lands a few cycles before the first would complete
      cyc(34);
      wr(8'h00, 32'h9000);
      cyc(25);
      chk("aborted", ic0, b);
      cyc(40);
      chk("restarted", ic0, b + 1);
      wr(8'h00, 32'h9000);
      b = ic0;
      cyc(10);
      // enable low mid-conversion must hold the sequence where it is
      ce <= 1'b0;
      cyc(100);
      chk("frozen", ic0, b);
      ce <= 1'b1;
      wirq(0, b + 1);
      for (k = 0; k < 4; k++) begin
         wr(8'h08, k);
         wr(8'h00, 32'h9101);
         b = ic0;
         cyc(60);
         chk("armed idle", ic0, b);
         rchk("armed status", 8'h00, 32'hD101);
         pulse((k + 1) % 4);
         cyc(60);
         chk("other event", ic0, b);
         pulse(k);
         wirq(0, b + 1);
         rchk("standby again", 8'h00, 32'hD101);
      end
      rchk("timer result", 8'h24, lvl(0, 1));
      for (k = 1; k < 4; k++) begin
         wr(8'h0C, k << 2);
         wr(8'h04, 32'h9707);
         b = ic1;
         @(posedge sys_clk);
         pin[1] <= 1'b1;
         cyc(80);
         chk("rising edge", ic1, b + (k != 2));
         @(posedge sys_clk);
         pin[1] <= 1'b0;
         cyc(80);
         chk("falling edge", ic1, b + (k != 2) + (k != 1));
      end
      rchk("ext result", 8'h5C, lvl(1, 7));
      finish_test();
   end
endmodule : tb_adc_conversion_sequencer
